// *** ddr3_init_mrs.sv ***
// device-side reset, initialisation and mode register load logic with apb status
//
// Behaviour
// - cke must stay low 500 us after reset release; device initialises internally
// - termination stays high impedance during reset until cke registered high
// - bank bits 1:0 pick the mode register, bank bit 2 must be low
// - consecutive mode loads spaced by at least mode_set_cycle_time
// - write termination applies anyway; no dynamic switching while leveling
// - pattern select bits ignored while register 3 bit 2 is clear
// - auto self refresh is bit 6 set, bit 7 clear; both set illegal
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/10ps
`include "ddr3_init_defs.svh"
module ddr3_init_mrs #(
  parameter int INIT_CYCLES = `INIT_WAIT_CYCLES,
  parameter int MRD_CYCLES  = `MRD_CYCLES,
  parameter int XPR_CYCLES  = `XPR_CYCLES,
  parameter int CAL_CYCLES  = (`DLL_LOCK_CYCLES > `ZQ_INIT_CYCLES) ?
                              `DLL_LOCK_CYCLES : `ZQ_INIT_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dram_reset_n,
  input  wire logic        cke,
  input  wire logic        odt,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [14:0] addr,
  output logic             term_enable,
  output logic             dynamic_term_enable,
  output logic [1:0]       write_term_sel,
  output logic             pattern_readout_en,
  output logic [1:0]       pattern_sel,
  output logic             auto_self_refresh,
  output logic             init_done
);
  localparam int CW = $clog2(INIT_CYCLES + 1);
  localparam int SW = $clog2(MRD_CYCLES + 1);

  // synchronised pins: reset, cke, odt, cs, ras, cas, we, ba, addr
  logic [24:0] pins_s;
  logic        rst_s;
  logic        cke_s;
  logic        odt_s;
  logic [3:0]  cmd_s;
  logic [2:0]  ba_s;
  logic [14:0] addr_s;

  pin_sync #(.W(25), .RESET_VAL(25'h03c0000)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     ({dram_reset_n, cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr}),
    .level   (pins_s)
  );
  assign {rst_s, cke_s, odt_s, cmd_s, ba_s, addr_s} = pins_s;

  ddr3_init_pkg::state_t    state;
  ddr3_init_pkg::state_t    next_state;
  logic [CW-1:0]            cnt;
  logic [CW-1:0]            next_cnt;
  logic [SW-1:0]            gap;
  logic [SW-1:0]            next_gap;
  logic [14:0]              mr [4];
  logic [14:0]              next_mr [4];
  logic [1:0]               step;
  logic [1:0]               next_step;
  logic [`FLAG_W-1:0]       flags;
  logic [`FLAG_W-1:0]       next_flags;
  logic                     strict;
  logic                     next_strict;
  logic                     cmd_prev;
  logic                     mrs_now;
  logic                     zq_now;
  logic                     cmd_new;
  logic                     load_phase;
  logic                     order_ok;
  logic [1:0]               want;
  logic                     next_term_enable;
  logic                     next_init_done;
  logic [31:0]              next_prdata;
  logic                     next_pready;
  logic                     next_pslverr;
  logic                     wr_take;
  logic                     rd_take;
  logic                     mapped;
  logic [`FLAG_W-1:0]       clear_bits;

  // commands are taken once, on the cycle the sampled command first appears
  assign mrs_now = cke_s && (cmd_s == 4'h0);
  assign zq_now  = cke_s && (cmd_s == 4'h6) && addr_s[`BIT_ZQ_LONG];
  assign cmd_new = (mrs_now || zq_now) && !cmd_prev;

  always_comb begin
    unique case (step)
      2'd0: want = 2'd2;
      2'd1: want = 2'd3;
      2'd2: want = 2'd1;
      2'd3: want = 2'd0;
    endcase
  end

  assign load_phase = (state == ddr3_init_pkg::S_LOAD);
  assign order_ok   = (ba_s[1:0] == want) &&
                      !(want == 2'd1 && addr_s[`BIT_MR1_DLL_OFF]) &&
                      !(want == 2'd0 && !addr_s[`BIT_MR0_DLL_RST]);

  always_comb begin
    next_state = state;
    next_cnt   = (cnt != '0) ? cnt - 1'b1 : cnt;
    next_gap   = (gap != '0) ? gap - 1'b1 : gap;
    next_step  = step;
    next_flags = flags & ~clear_bits;
    for (int i = 0; i < 4; i++) begin
      next_mr[i] = mr[i];
    end
    unique case (state)
      ddr3_init_pkg::S_RESET: begin
        if (rst_s) begin
          next_state = ddr3_init_pkg::S_INTERNAL;
          next_cnt   = CW'(INIT_CYCLES - 1);
        end
      end
      ddr3_init_pkg::S_INTERNAL: begin
        if (cke_s) begin
          next_flags[`FLAG_CKE_EARLY] = 1'b1;
        end
        if (cnt == '0) begin
          next_state = ddr3_init_pkg::S_WAIT_CKE;
        end
      end
      ddr3_init_pkg::S_WAIT_CKE: begin
        if (cke_s) begin
          next_state = ddr3_init_pkg::S_XPR;
          next_cnt   = CW'(XPR_CYCLES - 1);
        end
      end
      ddr3_init_pkg::S_XPR: begin
        if (mrs_now && cmd_new) begin
          next_flags[`FLAG_MRS_EARLY] = 1'b1;
        end
        if (cnt == '0) begin
          next_state = ddr3_init_pkg::S_LOAD;
          next_step  = 2'd0;
        end
      end
      ddr3_init_pkg::S_LOAD: begin
        if (zq_now && cmd_new) begin
          if (step == 2'd3 && mr[0][`BIT_MR0_DLL_RST] && gap == '0) begin
            next_state = ddr3_init_pkg::S_CAL;
            next_cnt   = CW'(CAL_CYCLES - 1);
          end else begin
            next_flags[`FLAG_ORDER] = 1'b1;
          end
        end
      end
      ddr3_init_pkg::S_CAL: begin
        if (cnt == '0) begin
          next_state = ddr3_init_pkg::S_READY;
        end
      end
      ddr3_init_pkg::S_READY: begin
      end
    endcase
    // mode register set decode, shared by load phase and normal operation
    if (mrs_now && cmd_new && (load_phase || state == ddr3_init_pkg::S_READY)) begin
      next_gap = SW'(MRD_CYCLES - 1);
      if (gap != '0) begin
        next_flags[`FLAG_SPACING] = 1'b1;
      end
      if (ba_s[2]) begin
        next_flags[`FLAG_BANK] = 1'b1;
      end else if (load_phase && !order_ok && strict) begin
        next_flags[`FLAG_ORDER] = 1'b1;
      end else begin
        next_mr[ba_s[1:0]] = addr_s;
        if (load_phase && order_ok) begin
          next_step = (step == 2'd3) ? step : step + 1'b1;
        end else if (load_phase) begin
          next_flags[`FLAG_ORDER] = 1'b1;
        end
        if (ba_s[1:0] == 2'd2 && addr_s[`BIT_MR2_ASR] && addr_s[`BIT_MR2_SRT]) begin
          next_flags[`FLAG_ASR] = 1'b1;
        end
      end
    end
    if (!rst_s) begin
      next_state = ddr3_init_pkg::S_RESET;
      next_cnt   = '0;
      next_gap   = '0;
      next_step  = 2'd0;
      for (int i = 0; i < 4; i++) begin
        next_mr[i] = '0;
      end
    end
  end

  // termination leaves high impedance only once cke is seen after reset
  always_comb begin
    next_term_enable = !(next_state inside {ddr3_init_pkg::S_RESET,
                         ddr3_init_pkg::S_INTERNAL, ddr3_init_pkg::S_WAIT_CKE});
    next_init_done   = (next_state == ddr3_init_pkg::S_READY);
  end

  // apb slave: one wait state, then data and pready together
  assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= `OFS_FLAG_CLEAR);
  assign rd_take = psel && penable && !pready;
  assign wr_take = psel && penable && pready && pwrite && mapped;

  always_comb begin
    next_pready  = rd_take;
    next_pslverr = rd_take && !mapped;
    next_prdata  = prdata;
    next_strict  = strict;
    clear_bits   = '0;
    if (wr_take && paddr == `OFS_CONTROL) begin
      next_strict = pwdata[0];
    end
    if (wr_take && paddr == `OFS_FLAG_CLEAR) begin
      clear_bits = pwdata[`FLAG_W-1:0];
    end
    if (rd_take) begin
      unique case (paddr)
        `OFS_STATUS:  next_prdata = {8'h00, 2'b00, flags, 8'h00, init_done, state};
        `OFS_MR0:     next_prdata = {17'h00000, mr[0]};
        `OFS_MR1:     next_prdata = {17'h00000, mr[1]};
        `OFS_MR2:     next_prdata = {17'h00000, mr[2]};
        `OFS_MR3:     next_prdata = {17'h00000, mr[3]};
        `OFS_CONTROL: next_prdata = {31'h00000000, strict};
        default:      next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state               <= ddr3_init_pkg::S_RESET;
      cnt                 <= '0;
      gap                 <= '0;
      step                <= 2'd0;
      flags               <= '0;
      strict              <= `CONTROL_RESET;
      cmd_prev            <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        mr[i] <= '0;
      end
      term_enable         <= 1'b0;
      dynamic_term_enable <= 1'b0;
      write_term_sel      <= 2'b00;
      pattern_readout_en  <= 1'b0;
      pattern_sel         <= 2'b00;
      auto_self_refresh   <= 1'b0;
      init_done           <= 1'b0;
      prdata              <= 32'h00000000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
    end else begin
      state               <= next_state;
      cnt                 <= next_cnt;
      gap                 <= next_gap;
      step                <= next_step;
      flags               <= next_flags;
      strict              <= next_strict;
      cmd_prev            <= mrs_now || zq_now;
      for (int i = 0; i < 4; i++) begin
        mr[i] <= next_mr[i];
      end
      term_enable         <= next_term_enable;
      dynamic_term_enable <= next_init_done && !next_mr[1][`BIT_MR1_WLEVEL];
      write_term_sel      <= next_mr[2][`POS_MR2_WTERM +: 2];
      pattern_readout_en  <= next_mr[3][`BIT_MR3_PATTERN];
      pattern_sel         <= next_mr[3][`BIT_MR3_PATTERN] ? next_mr[3][1:0] : 2'b00;
      auto_self_refresh   <= next_mr[2][`BIT_MR2_ASR] && !next_mr[2][`BIT_MR2_SRT];
      init_done           <= next_init_done;
      prdata              <= next_prdata;
      pready              <= next_pready;
      pslverr             <= next_pslverr;
    end
  end

  reset_hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rst_s |=> !term_enable) else $error("termination on during reset");
  cke_early_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ddr3_init_pkg::S_INTERNAL && cke_s) |=> flags[`FLAG_CKE_EARLY])
    else $error("early cke not flagged");
  init_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state == ddr3_init_pkg::S_INTERNAL) |->
    cnt == CW'(INIT_CYCLES - 1)) else $error("init wait not reloaded");
  bank_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mrs_now && cmd_new && rst_s && !ba_s[2] && state == ddr3_init_pkg::S_READY)
    |=> mr[$past(ba_s[1:0])] == $past(addr_s)) else $error("mode load lost");
  bank_two_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mrs_now && cmd_new && rst_s && ba_s[2] && (load_phase || state == ddr3_init_pkg::S_READY))
    |=> flags[`FLAG_BANK] && $stable(mr[0]) && $stable(mr[2]))
    else $error("bank two load accepted");
  spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mrs_now && cmd_new && gap != '0 && (load_phase || state == ddr3_init_pkg::S_READY))
    |=> flags[`FLAG_SPACING]) else $error("spacing not flagged");
  wlevel_a: assert property (@(posedge pclk) disable iff (!presetn)
    mr[1][`BIT_MR1_WLEVEL] |-> !dynamic_term_enable)
    else $error("dynamic termination while leveling");
  pattern_a: assert property (@(posedge pclk) disable iff (!presetn)
    !mr[3][`BIT_MR3_PATTERN] |-> pattern_sel == 2'b00 && !pattern_readout_en)
    else $error("pattern select not ignored");
  asr_a: assert property (@(posedge pclk) disable iff (!presetn)
    auto_self_refresh == (mr[2][`BIT_MR2_ASR] && !mr[2][`BIT_MR2_SRT]))
    else $error("auto self refresh mismatch");
endmodule

// *** ddr3_init_defs.svh ***
// offsets, field positions, reset values and timing counts of the init block
`ifndef DDR3_INIT_DEFS_SVH
`define DDR3_INIT_DEFS_SVH
`define PCLK_PERIOD_NS    5
`define INIT_WAIT_US      500
`define INIT_WAIT_CYCLES  ((`INIT_WAIT_US * 1000 + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)
`define MRD_CYCLES        4
`define XPR_CYCLES        5
`define DLL_LOCK_CYCLES   512
`define ZQ_INIT_CYCLES    512
`define OFS_STATUS        8'h00
`define OFS_MR0           8'h04
`define OFS_MR1           8'h08
`define OFS_MR2           8'h0c
`define OFS_MR3           8'h10
`define OFS_CONTROL       8'h14
`define OFS_FLAG_CLEAR    8'h18
`define CONTROL_RESET     1'b1
`define BIT_MR1_DLL_OFF   0
`define BIT_MR1_WLEVEL    7
`define BIT_MR1_WL_TERM   12
`define BIT_MR0_DLL_RST   8
`define BIT_MR2_ASR       6
`define BIT_MR2_SRT       7
`define POS_MR2_WTERM     9
`define BIT_MR3_PATTERN   2
`define BIT_ZQ_LONG       10
`define FLAG_CKE_EARLY    0
`define FLAG_MRS_EARLY    1
`define FLAG_SPACING      2
`define FLAG_BANK         3
`define FLAG_ORDER        4
`define FLAG_ASR          5
`define FLAG_W            6
`endif

// *** ddr3_init_pkg.sv ***
// types shared by the init block
package ddr3_init_pkg;
  typedef enum logic [6:0] {
    S_RESET    = 7'b0000001,
    S_INTERNAL = 7'b0000010,
    S_WAIT_CKE = 7'b0000100,
    S_XPR      = 7'b0001000,
    S_LOAD     = 7'b0010000,
    S_CAL      = 7'b0100000,
    S_READY    = 7'b1000000
  } state_t;
endpackage

// *** pin_sync.sv ***
// three-stage pin synchroniser, a change counts once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
  parameter int           W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_level;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        next_level[i] = (s2[i] == s3[i]) ? s3[i] : level[i];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1    <= RESET_VAL;
      s2    <= RESET_VAL;
      s3    <= RESET_VAL;
      level <= RESET_VAL;
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end
endmodule

// *** ddr3_ctrl_model.sv ***
// behavioural memory controller driving the dram reset, clock enable and command pins
`timescale 1ns/10ps
module ddr3_ctrl_model (
  input  wire logic   pclk,
  input  wire logic   go_reset_n,
  input  wire logic   go_cke,
  input  wire logic   req,
  input  wire logic [3:0]  req_cmd,
  input  wire logic [2:0]  req_ba,
  input  wire logic [14:0] req_addr,
  output logic        ack,
  output logic        dram_reset_n,
  output logic        cke,
  output logic        odt,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [14:0] addr
);
  // startup code: drive deselect once on the first edge
  logic [1:0] held = 2'd3;

  // the pclk keeps running, so the clock is stable well before cke rises
  // a command is held two clocks, then deselect with the address lines flipped
  always @(posedge pclk) begin
    dram_reset_n <= go_reset_n;
    cke          <= go_cke && go_reset_n;
    odt          <= 1'b0;
    ack          <= 1'b0;
    if (held == 2'd3) begin
      {cs_n, ras_n, cas_n, we_n} <= 4'b1111;
      ba   <= 3'h0;
      addr <= 15'h0000;
      held <= 2'd0;
    end else if (held == 2'd0 && req && !ack) begin
      {cs_n, ras_n, cas_n, we_n} <= req_cmd;
      ba   <= req_ba;
      addr <= req_addr;
      held <= 2'd1;
    end else if (held == 2'd1) begin
      held <= 2'd2;
    end else if (held == 2'd2) begin
      {cs_n, ras_n, cas_n, we_n} <= 4'b1111;
      ba   <= ~ba;
      addr <= ~addr;
      ack  <= 1'b1;
      held <= 2'd0;
    end
  end
endmodule

// *** ddr3_init_and_mode_register_setup_tb_top.sv ***
// self-checking bench for the ddr3 init and mode register block
`timescale 1ns/10ps
`include "ddr3_init_defs.svh"
module ddr3_init_and_mode_register_setup_tb_top;
  localparam logic [31:0] ST_LOAD = 32'(ddr3_init_pkg::S_LOAD);
  localparam logic [31:0] ST_RDY  = 32'(ddr3_init_pkg::S_READY) | 32'h80;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        dram_reset_n, cke, odt, cs_n, ras_n, cas_n, we_n;
  logic [2:0]  ba;
  logic [14:0] addr;
  logic        go_reset_n, go_cke, req, ack;
  logic [3:0]  req_cmd;
  logic [2:0]  req_ba;
  logic [14:0] req_addr;
  logic        term_enable, dynamic_term_enable, pattern_readout_en, auto_self_refresh;
  logic        init_done;
  logic [1:0]  write_term_sel, pattern_sel;
  int          mismatches;
  int          comparisons;

  ddr3_init_mrs #(.INIT_CYCLES(60), .MRD_CYCLES(8), .XPR_CYCLES(8), .CAL_CYCLES(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dram_reset_n(dram_reset_n), .cke(cke), .odt(odt), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .term_enable(term_enable),
    .dynamic_term_enable(dynamic_term_enable), .write_term_sel(write_term_sel),
    .pattern_readout_en(pattern_readout_en), .pattern_sel(pattern_sel),
    .auto_self_refresh(auto_self_refresh), .init_done(init_done));
  ddr3_ctrl_model partner (
    .pclk(pclk), .go_reset_n(go_reset_n), .go_cke(go_cke), .req(req), .req_cmd(req_cmd),
    .req_ba(req_ba), .req_addr(req_addr), .ack(ack), .dram_reset_n(dram_reset_n),
    .cke(cke), .odt(odt), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr));

  always #2.5 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer: setup, access, hold until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, q, exp);
  endtask
  task automatic clr_flags;
    apb(1'b1, `OFS_FLAG_CLEAR, 32'hffffffff, rd, err);
  endtask
  task automatic wait_state(input logic [6:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, `OFS_STATUS, 32'h0, rd, err);
      n++;
    end while (rd[6:0] !== s && n < 200);
    chk("state", 32'(rd[6:0]), 32'(s));
  endtask
  task automatic set_reset(input logic v);
    @(posedge pclk);
    go_reset_n <= v;
    if (!v) begin
      go_cke <= 1'b0;
    end
  endtask
  task automatic set_cke(input logic v);
    @(posedge pclk);
    go_cke <= v;
  endtask
  // request held until the partner acknowledges the command
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a,
                       input int gap);
    @(posedge pclk);
    req      <= 1'b1;
    req_cmd  <= c;
    req_ba   <= b;
    req_addr <= a;
    do begin
      @(posedge pclk);
    end while (ack !== 1'b1);
    req <= 1'b0;
    repeat (gap) @(posedge pclk);
  endtask
  task automatic mrs(input logic [1:0] r, input logic [14:0] v, input int gap);
    issue(4'b0000, {1'b0, r}, v, gap);
  endtask

  task automatic t_regs;
    rd_chk(`OFS_STATUS, 32'(ddr3_init_pkg::S_RESET), "status_reset");
    chk("term_reset", 32'(term_enable), 32'h0);
    rd_chk(`OFS_CONTROL, 32'(`CONTROL_RESET), "control_reset");
    apb(1'b1, `OFS_MR0, 32'h00007fff, rd, err);
    rd_chk(`OFS_MR0, 32'h0, "mr0_readonly");
    apb(1'b0, 8'h1c, 32'h0, rd, err);
    chk("unmapped_err", 32'(err), 32'h1);
    chk("unmapped_data", rd, 32'h0);
    apb(1'b0, 8'h02, 32'h0, rd, err);
    chk("misaligned_err", 32'(err), 32'h1);
    apb(1'b1, `OFS_CONTROL, 32'h0, rd, err);
    rd_chk(`OFS_CONTROL, 32'h0, "control_rw");
    apb(1'b1, `OFS_CONTROL, 32'h1, rd, err);
  endtask

  task automatic t_powerup;
    set_reset(1'b1);
    wait_state(ddr3_init_pkg::S_INTERNAL);
    set_cke(1'b1);
    // long enough to pass the pin filter, then let the flag settle
    repeat (2) @(posedge pclk);
    set_cke(1'b0);
    repeat (4) @(posedge pclk);
    rd_chk(`OFS_STATUS, 32'h0001_0000 | 32'(ddr3_init_pkg::S_INTERNAL), "cke_early");
    clr_flags();
    wait_state(ddr3_init_pkg::S_WAIT_CKE);
    chk("term_before_cke", 32'(term_enable), 32'h0);
    set_cke(1'b1);
    mrs(2'b10, 15'h0440, 12);
    rd_chk(`OFS_STATUS, 32'h0002_0000 | ST_LOAD, "mrs_in_xpr");
    rd_chk(`OFS_MR2, 32'h0, "mr2_ignored");
    chk("term_after_cke", 32'(term_enable), 32'h1);
    clr_flags();
    mrs(2'b01, 15'h0004, 12);
    rd_chk(`OFS_STATUS, 32'h0010_0000 | ST_LOAD, "order_flag");
    rd_chk(`OFS_MR1, 32'h0, "mr1_ignored");
    clr_flags();
    mrs(2'b10, 15'h0440, 12);
    mrs(2'b11, 15'h0007, 12);
    mrs(2'b01, 15'h0004, 12);
    mrs(2'b00, 15'h0120, 12);
    chk("wterm", 32'(write_term_sel), 32'h2);
    chk("asr_on", 32'(auto_self_refresh), 32'h1);
    chk("pattern_on", {29'h0, pattern_readout_en, pattern_sel}, 32'h7);
    rd_chk(`OFS_MR0, 32'h0120, "mr0");
    rd_chk(`OFS_MR1, 32'h0004, "mr1");
    rd_chk(`OFS_MR2, 32'h0440, "mr2");
    rd_chk(`OFS_MR3, 32'h0007, "mr3");
    chk("done_early", 32'(init_done), 32'h0);
    issue(4'b0110, 3'b000, 15'h0400, 4);
    wait_state(ddr3_init_pkg::S_READY);
    chk("init_done", 32'(init_done), 32'h1);
    chk("dyn_term_on", 32'(dynamic_term_enable), 32'h1);
    rd_chk(`OFS_STATUS, ST_RDY, "status_ready");
  endtask

  task automatic t_ready;
    mrs(2'b11, 15'h0003, 0);
    mrs(2'b11, 15'h0003, 12);
    rd_chk(`OFS_STATUS, 32'h0004_0000 | ST_RDY, "spacing");
    chk("pattern_ignored", {29'h0, pattern_readout_en, pattern_sel}, 32'h0);
    issue(4'b0000, 3'b110, 15'h0000, 12);
    chk("ba2_ignored", 32'(write_term_sel), 32'h2);
    rd_chk(`OFS_STATUS, 32'h000c_0000 | ST_RDY, "ba2_flag");
    mrs(2'b10, 15'h00c0, 12);
    rd_chk(`OFS_STATUS, 32'h002c_0000 | ST_RDY, "asr_srt");
    chk("asr_off", 32'(auto_self_refresh), 32'h0);
    mrs(2'b01, 15'h0080, 12);
    chk("dyn_term_wl", 32'(dynamic_term_enable), 32'h0);
    clr_flags();
  endtask

  task automatic t_reset;
    set_reset(1'b0);
    repeat (6) @(posedge pclk);
    clr_flags();
    rd_chk(`OFS_STATUS, 32'(ddr3_init_pkg::S_RESET), "status_rereset");
    chk("term_rereset", 32'(term_enable), 32'h0);
    chk("done_rereset", 32'(init_done), 32'h0);
    rd_chk(`OFS_MR1, 32'h0, "mr1_cleared");
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    stop_test();
  end

  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    go_reset_n  = 1'b0;
    go_cke      = 1'b0;
    req         = 1'b0;
    req_cmd     = 4'hf;
    req_ba      = 3'h0;
    req_addr    = 15'h0000;
    mismatches  = 0;
    comparisons = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_powerup();
    t_ready();
    t_reset();
    stop_test();
  end
endmodule
